// file: logic/slow_xcvr_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - Enable control low drives, high tri-states
// - Direction high fast-to-slow, low slow-to-fast
// - Idle keeps enabled, fast-to-slow direction
// - Only slow-bus reads change the controls
// - Direction low two clocks after address
// - Peripheral enables wait three clocks
// - Read end disables transceiver two clocks
// - Direction returns one clock after disable
// - Turnaround after every read, even back-to-back
// - No turnaround between burst transfers
// - Eight readable, three writable registers
module slow_xcvr_ctrl #(
  parameter int unsigned WIDTH = slow_xcvr_pkg::REG_WIDTH
) (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst_b,
  // Processor bus
  input  wire slow_xcvr_pkg::proc_bus_t bus,
  // Transceiver and peripheral gating
  output var slow_xcvr_pkg::xcvr_ctl_t  ctl,
  // Register access
  input  wire logic                     reg_wr_en,
  input  wire logic                     reg_rd_en,
  input  wire logic [2:0]               reg_addr,
  input  wire logic [WIDTH-1:0]         reg_wdata,
  output logic      [WIDTH-1:0]         reg_rdata
);

  slow_xcvr_pkg::xcvr_state_t state;
  slow_xcvr_pkg::xcvr_state_t next_state;
  logic                       pending;
  logic                       next_pending;
  logic [WIDTH-1:0]           read_count;
  logic [WIDTH-1:0]           next_read_count;
  logic [WIDTH-1:0]           beat_count;
  logic [WIDTH-1:0]           next_beat_count;
  logic                       slow_read;
  logic                       read_end;
  logic                       beat_done;
  logic [8*WIDTH-1:0]         ro_values;
  logic [3*WIDTH-1:0]         cfg_values;

  assign slow_read = !bus.addr_strobe_n && bus.slow_sel && !bus.is_write;
  assign beat_done = !bus.ready_n;
  assign read_end  = !bus.last_transfer_n && !bus.ready_n;

  always_comb begin
    next_state      = state;
    next_pending    = pending;
    next_read_count = read_count;
    next_beat_count = beat_count;
    unique case (state)
      slow_xcvr_pkg::ST_IDLE: begin
        if (slow_read) begin
          next_state = slow_xcvr_pkg::ST_ADDR_WAIT;
        end
      end
      slow_xcvr_pkg::ST_ADDR_WAIT: begin
        next_state = slow_xcvr_pkg::ST_READ_WAIT;
      end
      slow_xcvr_pkg::ST_READ_WAIT: begin
        next_state = slow_xcvr_pkg::ST_READ;
      end
      slow_xcvr_pkg::ST_READ: begin
        if (beat_done) begin
          next_beat_count = beat_count + 1'b1;
        end
        if (read_end) begin
          next_state      = slow_xcvr_pkg::ST_OFF1;
          next_read_count = read_count + 1'b1;
        end
      end
      slow_xcvr_pkg::ST_OFF1: begin
        next_state   = slow_xcvr_pkg::ST_OFF2;
        next_pending = slow_read;
      end
      // Address one cycle earlier already used up the first wait clock
      slow_xcvr_pkg::ST_OFF2: begin
        next_pending = 1'b0;
        if (pending) begin
          next_state = slow_xcvr_pkg::ST_READ_WAIT;
        end else if (slow_read) begin
          next_state = slow_xcvr_pkg::ST_ADDR_WAIT;
        end else begin
          next_state = slow_xcvr_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = slow_xcvr_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state      <= slow_xcvr_pkg::ST_IDLE;
      pending    <= 1'b0;
      read_count <= '0;
      beat_count <= '0;
    end else begin
      state      <= next_state;
      pending    <= next_pending;
      read_count <= next_read_count;
      beat_count <= next_beat_count;
    end
  end

  always_comb begin
    ctl.slow_side_xcvr_enable_n  = 1'b0;
    ctl.slow_side_xcvr_direction = 1'b1;
    ctl.periph_oe_ok             = 1'b0;
    unique case (state)
      slow_xcvr_pkg::ST_READ_WAIT: begin
        ctl.slow_side_xcvr_direction = 1'b0;
      end
      slow_xcvr_pkg::ST_READ: begin
        ctl.slow_side_xcvr_direction = 1'b0;
        ctl.periph_oe_ok             = 1'b1;
      end
      slow_xcvr_pkg::ST_OFF1: begin
        ctl.slow_side_xcvr_enable_n  = 1'b1;
        ctl.slow_side_xcvr_direction = 1'b0;
      end
      slow_xcvr_pkg::ST_OFF2: begin
        ctl.slow_side_xcvr_enable_n  = 1'b1;
      end
      default: begin
        ctl.slow_side_xcvr_enable_n  = 1'b0;
      end
    endcase
  end

  assign ro_values = {
    slow_xcvr_pkg::IDENT_VALUE,
    slow_xcvr_pkg::IDENT_VALUE,
    beat_count,
    read_count,
    WIDTH'({ctl.periph_oe_ok, ctl.slow_side_xcvr_direction,
            ctl.slow_side_xcvr_enable_n, state}),
    {3*WIDTH{1'b0}}
  };

  misc_reg_file #(
    .WIDTH (WIDTH),
    .N_WR  (slow_xcvr_pkg::REG_WRITE_CNT),
    .N_RD  (slow_xcvr_pkg::REG_READ_CNT),
    .ADDR_W(slow_xcvr_pkg::REG_ADDR_W)
  ) u_regs (
    .clock     (clock),
    .rst_b     (rst_b),
    .wr_en     (reg_wr_en),
    .rd_en     (reg_rd_en),
    .addr      (reg_addr),
    .wdata     (reg_wdata),
    .rdata     (reg_rdata),
    .ro_values (ro_values),
    .cfg_values(cfg_values)
  );

  AST_IDLE_DEFAULT: assert property (@(posedge clock) disable iff (!rst_b)
    (state == slow_xcvr_pkg::ST_IDLE) |->
      (!ctl.slow_side_xcvr_enable_n && ctl.slow_side_xcvr_direction))
    else $error("idle controls not default");

  AST_OTHER_UNCHANGED: assert property (@(posedge clock) disable iff (!rst_b)
    (state == slow_xcvr_pkg::ST_IDLE && !bus.addr_strobe_n && !slow_read) |=>
      (!ctl.slow_side_xcvr_enable_n && ctl.slow_side_xcvr_direction)[*2])
    else $error("controls changed on non slow read");

  AST_DIR_TWO_CLOCKS: assert property (@(posedge clock) disable iff (!rst_b)
    (state == slow_xcvr_pkg::ST_IDLE && slow_read) |->
      ##1 ctl.slow_side_xcvr_direction ##1 !ctl.slow_side_xcvr_direction)
    else $error("direction not low two clocks after address");

  AST_PERIPH_THREE: assert property (@(posedge clock) disable iff (!rst_b)
    (state == slow_xcvr_pkg::ST_IDLE && slow_read) |->
      ##1 !ctl.periph_oe_ok ##1 !ctl.periph_oe_ok ##1 ctl.periph_oe_ok)
    else $error("peripheral enable not on third clock");

  AST_DISABLE_TWO: assert property (@(posedge clock) disable iff (!rst_b)
    (state == slow_xcvr_pkg::ST_READ && read_end) |->
      ##1 ctl.slow_side_xcvr_enable_n [*2] ##1 !ctl.slow_side_xcvr_enable_n)
    else $error("enable not off for exactly two clocks");

  AST_DIR_RETURN: assert property (@(posedge clock) disable iff (!rst_b)
    (state == slow_xcvr_pkg::ST_READ && read_end) |->
      ##1 !ctl.slow_side_xcvr_direction ##1 ctl.slow_side_xcvr_direction)
    else $error("direction not restored one clock after disable");

  AST_BACK_TO_BACK: assert property (@(posedge clock) disable iff (!rst_b)
    (state == slow_xcvr_pkg::ST_READ && read_end) ##1 slow_read |->
      ##1 ctl.slow_side_xcvr_direction ##1 !ctl.slow_side_xcvr_direction ##1 ctl.periph_oe_ok)
    else $error("back to back read turnaround wrong");

  AST_BURST_HOLD: assert property (@(posedge clock) disable iff (!rst_b)
    (state == slow_xcvr_pkg::ST_READ && !read_end) |=>
      (!ctl.slow_side_xcvr_direction && !ctl.slow_side_xcvr_enable_n))
    else $error("controls moved inside burst");

  AST_DISABLE_CAUSE: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(ctl.slow_side_xcvr_enable_n) |-> $past(read_end) && $past(state == slow_xcvr_pkg::ST_READ))
    else $error("transceiver disabled without read end");

endmodule : slow_xcvr_ctrl
`default_nettype wire

// file: shared/slow_xcvr_pkg.sv
package slow_xcvr_pkg;

  // Cycle counts, all in processor bus clocks
  localparam int unsigned TURN_DELAY_CYCLES   = 2;
  localparam int unsigned PERIPH_DELAY_CYCLES = 3;
  localparam int unsigned DISABLE_CYCLES      = 2;

  // Register file shape
  localparam int unsigned REG_WIDTH     = 32;
  localparam int unsigned REG_READ_CNT  = 8;
  localparam int unsigned REG_WRITE_CNT = 3;
  localparam int unsigned REG_ADDR_W    = 3;

  // Read map indices
  localparam logic [2:0] REG_CFG0      = 3'h0;
  localparam logic [2:0] REG_CFG1      = 3'h1;
  localparam logic [2:0] REG_CFG2      = 3'h2;
  localparam logic [2:0] REG_STATUS    = 3'h3;
  localparam logic [2:0] REG_READ_CNT_IDX  = 3'h4;
  localparam logic [2:0] REG_BEAT_CNT  = 3'h5;
  localparam logic [2:0] REG_IDENT     = 3'h6;
  localparam logic [2:0] REG_SPARE     = 3'h7;

  // Reset values
  localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
  // Arbitrary identification value
  localparam logic [31:0] IDENT_VALUE = 32'h0000_5A01;

  // Processor bus signals sampled by the controller
  typedef struct packed {
    logic addr_strobe_n;
    logic is_write;
    logic slow_sel;
    logic ready_n;
    logic last_transfer_n;
  } proc_bus_t;

  // Transceiver controls driven out
  typedef struct packed {
    logic slow_side_xcvr_enable_n;
    logic slow_side_xcvr_direction;
    logic periph_oe_ok;
  } xcvr_ctl_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR_WAIT,
    ST_READ_WAIT,
    ST_READ,
    ST_OFF1,
    ST_OFF2
  } xcvr_state_t;

endpackage : slow_xcvr_pkg

// file: logic/misc_reg_file.sv
`timescale 1ns/1ps
`default_nettype none
module misc_reg_file #(
  parameter int unsigned WIDTH  = slow_xcvr_pkg::REG_WIDTH,
  parameter int unsigned N_WR   = slow_xcvr_pkg::REG_WRITE_CNT,
  parameter int unsigned N_RD   = slow_xcvr_pkg::REG_READ_CNT,
  parameter int unsigned ADDR_W = slow_xcvr_pkg::REG_ADDR_W
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst_b,
  // Access port
  input  wire logic                  wr_en,
  input  wire logic                  rd_en,
  input  wire logic [ADDR_W-1:0]     addr,
  input  wire logic [WIDTH-1:0]      wdata,
  output logic      [WIDTH-1:0]      rdata,
  // Live values for the read-only slots, slot 0 first
  input  wire logic [N_RD*WIDTH-1:0] ro_values,
  // Stored writable registers
  output logic      [N_WR*WIDTH-1:0] cfg_values
);

  logic [N_WR*WIDTH-1:0] next_cfg_values;
  logic [WIDTH-1:0]      next_rdata;

  always_comb begin
    next_cfg_values = cfg_values;
    next_rdata      = rdata;
    if (wr_en && (32'(addr) < N_WR)) begin
      next_cfg_values[32'(addr)*WIDTH +: WIDTH] = wdata;
    end
    // Writable slots read back their stored value, the rest read live values
    if (rd_en) begin
      if (32'(addr) < N_WR) begin
        next_rdata = cfg_values[32'(addr)*WIDTH +: WIDTH];
      end else begin
        next_rdata = ro_values[32'(addr)*WIDTH +: WIDTH];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg_values <= {N_WR{slow_xcvr_pkg::CFG_RESET}};
      rdata      <= '0;
    end else begin
      cfg_values <= next_cfg_values;
      rdata      <= next_rdata;
    end
  end

endmodule : misc_reg_file
`default_nettype wire

// file: sim/proc_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module proc_bus_master (
  // Clock
  input  wire logic                    clock,
  // Processor bus toward the controller
  output var slow_xcvr_pkg::proc_bus_t bus
);
  initial bus = 5'h13;

  // Runs one access from the current falling edge; returns one cycle after the last beat
  task automatic access(input logic wr, input logic sel, input int beats, input int gap);
    bus.addr_strobe_n = 1'b0;
    bus.is_write      = wr;
    bus.slow_sel      = sel;
    @(negedge clock);
    // Released lines flip so a stale value cannot pass for a held one
    bus.addr_strobe_n = 1'b1;
    bus.is_write      = ~wr;
    bus.slow_sel      = ~sel;
    repeat (2 + gap) @(negedge clock);
    for (int i = 0; i < beats; i++) begin
      if (i > 0 && gap > 0) begin
        bus.ready_n = 1'b1;
        repeat (gap) @(negedge clock);
      end
      bus.ready_n         = 1'b0;
      bus.last_transfer_n = (i != beats - 1);
      @(negedge clock);
    end
    bus.ready_n         = 1'b1;
    bus.last_transfer_n = 1'b1;
  endtask : access
endmodule : proc_bus_master
`default_nettype wire

// file: sim/slow_xcvr_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module slow_xcvr_ctrl_bench;
  localparam slow_xcvr_pkg::xcvr_ctl_t IDLE_CTL = 3'h2;
  logic                      clock     = 1'b0;
  logic                      rst_b     = 1'b0;
  logic                      reg_wr_en = 1'b0;
  logic                      reg_rd_en = 1'b0;
  logic [2:0]                reg_addr  = 3'h0;
  logic [31:0]               reg_wdata = 32'h0;
  logic [31:0]               reg_rdata;
  logic [31:0]               d;
  slow_xcvr_pkg::proc_bus_t  bus;
  slow_xcvr_pkg::xcvr_ctl_t  ctl;
  slow_xcvr_pkg::xcvr_ctl_t  trace [64];
  slow_xcvr_pkg::xcvr_ctl_t  exp_ctl [64];
  int                        mismatches  = 0;
  int                        comparisons = 0;

  always #20 clock = ~clock;

  proc_bus_master i_master (.clock(clock), .bus(bus));
  slow_xcvr_ctrl i_dut (.clock(clock), .rst_b(rst_b), .bus(bus), .ctl(ctl),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test

  task automatic reg_wr(input logic [2:0] a, input logic [31:0] v);
    reg_addr  = a;
    reg_wdata = v;
    reg_wr_en = 1'b1;
    @(negedge clock);
    reg_wr_en = 1'b0;
    @(negedge clock);
  endtask : reg_wr

  task automatic reg_rd(input logic [2:0] a, output logic [31:0] v);
    reg_addr  = a;
    reg_rd_en = 1'b1;
    @(negedge clock);
    reg_rd_en = 1'b0;
    v         = reg_rdata;
    @(negedge clock);
  endtask : reg_rd

  // Index k holds the controls seen in cycle k, cycle 0 being the first address cycle
  task automatic sample(input int n);
    for (int k = 0; k < n; k++) begin
      trace[k] = ctl;
      @(negedge clock);
    end
  endtask : sample

  task automatic clear_exp;
    foreach (exp_ctl[k]) exp_ctl[k] = IDLE_CTL;
  endtask : clear_exp

  // Overlays one slow read at address cycle a; fields only move away from IDLE_CTL, never back, so overlapping reads merge
  task automatic add_read(input int a, input int gap, input int beats, output int e);
    e = a + int'(slow_xcvr_pkg::PERIPH_DELAY_CYCLES) + gap + (beats - 1) * (gap + 1);
    for (int k = a + int'(slow_xcvr_pkg::TURN_DELAY_CYCLES); k <= e + 1; k++) begin
      exp_ctl[k].slow_side_xcvr_direction = 1'b0;
    end
    for (int k = a + int'(slow_xcvr_pkg::PERIPH_DELAY_CYCLES); k <= e; k++) begin
      exp_ctl[k].periph_oe_ok = 1'b1;
    end
    for (int k = e + 1; k <= e + int'(slow_xcvr_pkg::DISABLE_CYCLES); k++) begin
      exp_ctl[k].slow_side_xcvr_enable_n = 1'b1;
    end
  endtask : add_read

  task automatic compare_trace(input int n, input string name);
    for (int k = 0; k < n; k++) check(trace[k], exp_ctl[k]);
    $display("test %s done", name);
  endtask : compare_trace

  task automatic t_reset;
    // Hold through eight rising edges, release off the sampling edge
    repeat (8) @(posedge clock);
    @(negedge clock);
    check(ctl, IDLE_CTL);
    check(reg_rdata, 32'h0);
    rst_b = 1'b1;
    @(negedge clock);
    check(ctl, IDLE_CTL);
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs;
    for (int i = 0; i < 8; i++) reg_wr(i[2:0], 32'hA5A5_0000 + i);
    for (int i = 0; i < 8; i++) begin
      reg_rd(i[2:0], d);
      check(d, i < 3 ? 32'hA5A5_0000 + i : i == 3 ? 32'h10 : i < 6 ? 32'h0 : slow_xcvr_pkg::IDENT_VALUE);
    end
    $display("test regs done");
  endtask : t_regs

  task automatic t_other;
    clear_exp();
    fork
      begin
        i_master.access(1'b1, 1'b1, 1, 0);
        i_master.access(1'b0, 1'b0, 1, 1);
        i_master.access(1'b1, 1'b0, 2, 0);
      end
      sample(20);
    join
    compare_trace(20, "other");
  endtask : t_other

  task automatic t_single;
    int e;
    clear_exp();
    add_read(0, 0, 1, e);
    add_read(e + 2, 2, 1, e);
    fork
      begin
        i_master.access(1'b0, 1'b1, 1, 0);
        @(negedge clock);
        i_master.access(1'b0, 1'b1, 1, 2);
      end
      sample(16);
    join
    compare_trace(16, "single");
  endtask : t_single

  task automatic t_back_to_back;
    int e;
    clear_exp();
    add_read(0, 1, 1, e);
    add_read(e + 1, 0, 1, e);
    add_read(e + 1, 0, 2, e);
    fork
      begin
        i_master.access(1'b0, 1'b1, 1, 1);
        i_master.access(1'b0, 1'b1, 1, 0);
        i_master.access(1'b0, 1'b1, 2, 0);
      end
      sample(18);
    join
    compare_trace(18, "back_to_back");
  endtask : t_back_to_back

  task automatic t_burst;
    int e;
    clear_exp();
    add_read(0, 1, 4, e);
    fork
      i_master.access(1'b0, 1'b1, 4, 1);
      sample(16);
    join
    compare_trace(16, "burst");
  endtask : t_burst

  task automatic t_counts;
    reg_rd(slow_xcvr_pkg::REG_READ_CNT_IDX, d);
    check(d, 32'h6);
    reg_rd(slow_xcvr_pkg::REG_BEAT_CNT, d);
    check(d, 32'hA);
    $display("test counts done");
  endtask : t_counts

  initial begin
    t_reset();
    t_regs();
    t_other();
    t_single();
    t_back_to_back();
    t_burst();
    t_counts();
    finish_test();
  end

  initial begin
    #1_000_000;
    mismatches++;
    finish_test();
  end
endmodule : slow_xcvr_ctrl_bench
`default_nettype wire
